/* File: pkg/mcuri_consts.svh */
// Offsets, field masks, reset values and timing counts of the reset initializer
`ifndef MCURI_CONSTS_SVH
`define MCURI_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define MCURI_ADDR_W       8
`define MCURI_OFS_CTRL     8'h00
`define MCURI_OFS_STATUS   8'h04
`define MCURI_OFS_CPU      8'h08
`define MCURI_OFS_INTR     8'h0C
`define MCURI_OFS_PDATA    8'h10
`define MCURI_OFS_PDIR     8'h14
`define MCURI_OFS_PCFG     8'h18
`define MCURI_OFS_TCFG     8'h1C
`define MCURI_OFS_SERCMP   8'h20
`define MCURI_OFS_PRESC    8'h24
`define MCURI_OFS_COUNT    8'h28
`define MCURI_OFS_RELOAD   8'h2C
`define MCURI_NUM_WORDS    10

// ----------------------------------------------------------------------------
// Control and status bits
// ----------------------------------------------------------------------------
`define MCURI_CTRL_SOFT    0
`define MCURI_STAT_HOLD    0
`define MCURI_STAT_FETCH   1
`define MCURI_STAT_PIN     2
`define MCURI_STAT_MET     3

// ----------------------------------------------------------------------------
// Initial values, bits forced by reset, bits software may write
// ----------------------------------------------------------------------------
`define MCURI_INIT_CPU     32'h3FF1_0000
`define MCURI_FORCE_CPU    32'h3FF1_3FFF
`define MCURI_INIT_INTR    32'h003F_0000
`define MCURI_FORCE_INTR   32'h003F_3F01
`define MCURI_INIT_PDATA   32'h0000_FFFF
`define MCURI_FORCE_PDATA  32'h0000_FFFF
`define MCURI_FORCE_PDIR   32'hFFFF_FFFF
`define MCURI_FORCE_PCFG   32'h0003_0E13
`define MCURI_MASK_PCFG    32'h0003_0F13
`define MCURI_FORCE_TCFG   32'h030F_F7F7
`define MCURI_FORCE_SERCMP 32'h0007_0B1F
`define MCURI_MASK_SERCMP  32'h0007_0B3F
`define MCURI_FORCE_PRESC  32'h0007_07FF
`define MCURI_FORCE_COUNT  32'h00FF_FFFF
`define MCURI_FORCE_RELOAD 32'h0000_0F0F
`define MCURI_MASK_RELOAD  32'h0000_FFFF
`define MCURI_ZERO_WORD    32'h0000_0000

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define MCURI_INSTR_DIV    4
`define MCURI_HOLD_MIN     2

`endif

/* File: pkg/mcuri_pkg.sv */
// Types of the reset initializer: state machine, register words, state
package mcuri_pkg;

`include "mcuri_consts.svh"

	// ------------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		MCURI_HOLD  = 3'b001,
		MCURI_START = 3'b010,
		MCURI_RUN   = 3'b100
	} mcuri_state_e;

	// ------------------------------------------------------------------------
	// Register words
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  rsv2;
		logic [9:0]  stackPointer;
		logic [2:0]  rsv1;
		logic        branchStatusFlag;
		logic [1:0]  rsv0;
		logic [13:0] programCounter;
	} mcuri_cpu_s;

	typedef struct packed {
		logic [9:0] rsv2;
		logic [5:0] interruptMaskBit;
		logic [1:0] rsv1;
		logic [5:0] interruptRequestFlag;
		logic [6:0] rsv0;
		logic       globalInterruptEnable;
	} mcuri_intr_s;

	typedef struct packed {
		logic [15:0] rsv0;
		logic [15:0] portOutputData;
	} mcuri_pdata_s;

	typedef struct packed {
		logic [19:0] portDirectionGroupB;
		logic [11:0] portDirectionGroupA;
	} mcuri_pdir_s;

	typedef struct packed {
		logic [13:0] rsv3;
		logic [1:0]  edgeSelectSecond;
		logic [3:0]  rsv2;
		logic [3:0]  portConfigC;
		logic [2:0]  rsv1;
		logic        portConfigB;
		logic [1:0]  rsv0;
		logic [1:0]  portConfigA;
	} mcuri_pcfg_s;

	typedef struct packed {
		logic [5:0] rsv3;
		logic [1:0] miscConfig;
		logic [3:0] rsv2;
		logic [3:0] timerDConfigTwo;
		logic [3:0] timerDConfigOne;
		logic       rsv1;
		logic [2:0] timerCConfigTwo;
		logic [3:0] timerCConfigOne;
		logic       rsv0;
		logic [2:0] timerAConfig;
	} mcuri_tcfg_s;

	typedef struct packed {
		logic [12:0] rsv2;
		logic        captureErrorFlag;
		logic        captureStatusFlag;
		logic        watchdogActiveFlag;
		logic [3:0]  rsv1;
		logic [3:0]  comparatorEnableReg;
		logic [1:0]  rsv0;
		logic [1:0]  serialConfigB;
		logic [3:0]  serialConfigA;
	} mcuri_sercmp_s;

	typedef struct packed {
		logic [12:0] rsv1;
		logic [2:0]  octalCount;
		logic [4:0]  rsv0;
		logic [10:0] systemPrescaler;
	} mcuri_presc_s;

	typedef struct packed {
		logic [7:0] rsv0;
		logic [7:0] timerDCount;
		logic [7:0] timerCCount;
		logic [7:0] timerACount;
	} mcuri_count_s;

	typedef struct packed {
		logic [15:0] rsv0;
		logic [3:0]  timerDReloadHigh;
		logic [3:0]  timerDReloadLow;
		logic [3:0]  timerCReloadHigh;
		logic [3:0]  timerCReloadLow;
	} mcuri_reload_s;

	// ------------------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic second;
		logic first;
	} mcuri_sync_s;

	typedef struct packed {
		mcuri_state_e fsm;
		logic [1:0]   holdCnt;
		logic [7:0]   divCnt;
		logic         softReset;
		logic         ack;
		logic [31:0]  datO;
		logic [`MCURI_NUM_WORDS-1:0][31:0] word;
	} mcuri_core_s;

endpackage

/* File: logic/mcuri_sync.sv */
// Two-flop synchroniser with a constant reset level
`timescale 1ns/100ps

module mcuri_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Level in and out
	input  wire logic d,
	output logic      q
);

	mcuri_pkg::mcuri_sync_s state_reg;
	mcuri_pkg::mcuri_sync_s state_next;

	always_comb begin
		state_next.first = d;
		state_next.second = state_reg.first;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= {2{RESET_VAL}};
		end else begin
			state_reg <= state_next;
		end
	end

	assign q = state_reg.second;

endmodule // mcuri_sync

/* File: logic/mcuri_reset_initializer.sv */
// Reset sequencer and initial-value register file of the 4-bit core
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/100ps

`include "mcuri_consts.svh"

module mcuri_reset_initializer #(
	parameter int unsigned INSTR_DIV = `MCURI_INSTR_DIV
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rstn,
	// Reset pin from the supervisor, active high
	input  wire logic                         resetPin,
	// Wishbone slave
	input  wire logic                         wbCyc,
	input  wire logic                         wbStb,
	input  wire logic                         wbWe,
	input  wire logic [`MCURI_ADDR_W-1:0]     wbAdr,
	input  wire logic [3:0]                   wbSel,
	input  wire logic [31:0]                  wbDatI,
	output logic                              wbAck,
	output logic [31:0]                       wbDatO,
	// Core control
	output logic                              coreHold,
	output logic                              fetchEnable,
	output logic                              instrTick,
	// Initialised core state
	output mcuri_pkg::mcuri_cpu_s             cpuState,
	output mcuri_pkg::mcuri_intr_s            intrState,
	output mcuri_pkg::mcuri_pdata_s           portData,
	output mcuri_pkg::mcuri_pdir_s            portDir,
	output mcuri_pkg::mcuri_pcfg_s            portCfg,
	output mcuri_pkg::mcuri_tcfg_s            timerCfg,
	output mcuri_pkg::mcuri_sercmp_s          serCmp,
	output mcuri_pkg::mcuri_presc_s           prescState,
	output mcuri_pkg::mcuri_count_s           countState,
	output mcuri_pkg::mcuri_reload_s          reloadState
);

	// ------------------------------------------------------------------------
	// Word tables
	// ------------------------------------------------------------------------
	localparam int NW = `MCURI_NUM_WORDS;
	localparam logic [NW-1:0][31:0] WORD_INIT = {
		`MCURI_ZERO_WORD, `MCURI_ZERO_WORD, `MCURI_ZERO_WORD,
		`MCURI_ZERO_WORD, `MCURI_ZERO_WORD, `MCURI_ZERO_WORD,
		`MCURI_ZERO_WORD, `MCURI_INIT_PDATA, `MCURI_INIT_INTR,
		`MCURI_INIT_CPU};
	localparam logic [NW-1:0][31:0] WORD_FORCE = {
		`MCURI_FORCE_RELOAD, `MCURI_FORCE_COUNT, `MCURI_FORCE_PRESC,
		`MCURI_FORCE_SERCMP, `MCURI_FORCE_TCFG, `MCURI_FORCE_PCFG,
		`MCURI_FORCE_PDIR, `MCURI_FORCE_PDATA, `MCURI_FORCE_INTR,
		`MCURI_FORCE_CPU};
	localparam logic [NW-1:0][31:0] WORD_MASK = {
		`MCURI_MASK_RELOAD, `MCURI_FORCE_COUNT, `MCURI_FORCE_PRESC,
		`MCURI_MASK_SERCMP, `MCURI_FORCE_TCFG, `MCURI_MASK_PCFG,
		`MCURI_FORCE_PDIR, `MCURI_FORCE_PDATA, `MCURI_FORCE_INTR,
		`MCURI_FORCE_CPU};
	localparam logic [7:0] DIV_LAST = 8'(INSTR_DIV - 1);
	localparam mcuri_pkg::mcuri_core_s RESET_STATE = '{
		fsm:       mcuri_pkg::MCURI_HOLD,
		holdCnt:   2'h0,
		divCnt:    8'h00,
		softReset: 1'b0,
		ack:       1'b0,
		datO:      `MCURI_ZERO_WORD,
		word:      WORD_INIT};

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic [31:0] mergeSel(input logic [31:0] old,
			input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wr[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [31:0] applyInit(input logic [31:0] w,
			input int i);
		return (w & ~WORD_FORCE[i]) | (WORD_INIT[i] & WORD_FORCE[i]);
	endfunction

	// ------------------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------------------
	logic rstnSync;
	logic pinSync;

	mcuri_sync #(.RESET_VAL(1'b0)) u_rstSync (
		.clk  (clk),
		.rstn (rstn),
		.d    (1'b1),
		.q    (rstnSync)
	);

	mcuri_sync #(.RESET_VAL(1'b1)) u_pinSync (
		.clk  (clk),
		.rstn (rstnSync),
		.d    (resetPin),
		.q    (pinSync)
	);

	// ------------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------------
	mcuri_pkg::mcuri_core_s state_reg;
	mcuri_pkg::mcuri_core_s state_next;
	logic       busReq;
	logic       holdReq;
	logic       tick;
	logic       holdMet;
	logic       inStart;
	logic [5:0] wordAdr;
	logic [3:0] wordIdx;
	logic       wordHit;
	logic [31:0] statusWord;

	assign busReq  = wbCyc && wbStb && !state_reg.ack;
	assign holdReq = pinSync || state_reg.softReset;
	assign tick    = state_reg.divCnt == DIV_LAST;
	assign holdMet = state_reg.holdCnt >= 2'(`MCURI_HOLD_MIN);
	assign inStart = state_reg.fsm == mcuri_pkg::MCURI_START;
	assign wordAdr = wbAdr[7:2];
	assign wordIdx = 4'(wordAdr - 6'(`MCURI_OFS_CPU >> 2));
	assign wordHit = wordAdr >= 6'(`MCURI_OFS_CPU >> 2)
		&& wordAdr <= 6'(`MCURI_OFS_RELOAD >> 2);

	always_comb begin
		statusWord = `MCURI_ZERO_WORD;
		statusWord[`MCURI_STAT_HOLD]  = coreHold;
		statusWord[`MCURI_STAT_FETCH] = fetchEnable;
		statusWord[`MCURI_STAT_PIN]   = pinSync;
		statusWord[`MCURI_STAT_MET]   = holdMet;
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.divCnt = tick ? 8'h00 : 8'(state_reg.divCnt + 8'h01);
		// Bus access, one cycle answer, unmapped reads zero
		if (busReq) begin
			state_next.ack = 1'b1;
			state_next.datO = `MCURI_ZERO_WORD;
			if (wordAdr == 6'(`MCURI_OFS_CTRL >> 2)) begin
				state_next.datO[`MCURI_CTRL_SOFT] = state_reg.softReset;
				if (wbWe && wbSel[0]) begin
					state_next.softReset = wbDatI[`MCURI_CTRL_SOFT];
				end
			end else if (wordAdr == 6'(`MCURI_OFS_STATUS >> 2)) begin
				state_next.datO = statusWord;
			end else if (wordHit) begin
				state_next.datO = state_reg.word[wordIdx];
				if (wbWe) begin
					state_next.word[wordIdx] = mergeSel(
						state_reg.word[wordIdx], wbDatI, wbSel)
						& WORD_MASK[wordIdx];
				end
			end
		end
		// Sequencer
		case (state_reg.fsm)
			mcuri_pkg::MCURI_HOLD: begin
				if (!holdReq) begin
					state_next.fsm = mcuri_pkg::MCURI_START;
				end else if (tick && state_reg.holdCnt != 2'h3) begin
					state_next.holdCnt = 2'(state_reg.holdCnt + 2'h1);
				end
			end
			mcuri_pkg::MCURI_START: begin
				if (holdReq) begin
					state_next.fsm = mcuri_pkg::MCURI_HOLD;
					state_next.holdCnt = 2'h0;
				end else if (tick) begin
					state_next.fsm = mcuri_pkg::MCURI_RUN;
				end
			end
			mcuri_pkg::MCURI_RUN: begin
				if (holdReq) begin
					state_next.fsm = mcuri_pkg::MCURI_HOLD;
					state_next.holdCnt = 2'h0;
				end
			end
			default: begin
				state_next.fsm = mcuri_pkg::MCURI_HOLD;
				state_next.holdCnt = 2'h0;
			end
		endcase
		// Initial values win over writes while reset is held
		if (holdReq || state_reg.fsm == mcuri_pkg::MCURI_HOLD) begin
			for (int i = 0; i < NW; i++) begin
				state_next.word[i] = applyInit(state_next.word[i], i);
			end
		end
	end

	always_ff @(posedge clk or negedge rstnSync) begin
		if (!rstnSync) begin
			state_reg <= RESET_STATE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign wbAck       = state_reg.ack;
	assign wbDatO      = state_reg.datO;
	assign coreHold    = state_reg.fsm != mcuri_pkg::MCURI_RUN;
	assign fetchEnable = state_reg.fsm == mcuri_pkg::MCURI_RUN;
	assign instrTick   = tick;
	assign cpuState    = mcuri_pkg::mcuri_cpu_s'(state_reg.word[0]);
	assign intrState   = mcuri_pkg::mcuri_intr_s'(state_reg.word[1]);
	assign portData    = mcuri_pkg::mcuri_pdata_s'(state_reg.word[2]);
	assign portDir     = mcuri_pkg::mcuri_pdir_s'(state_reg.word[3]);
	assign portCfg     = mcuri_pkg::mcuri_pcfg_s'(state_reg.word[4]);
	assign timerCfg    = mcuri_pkg::mcuri_tcfg_s'(state_reg.word[5]);
	assign serCmp      = mcuri_pkg::mcuri_sercmp_s'(state_reg.word[6]);
	assign prescState  = mcuri_pkg::mcuri_presc_s'(state_reg.word[7]);
	assign countState  = mcuri_pkg::mcuri_count_s'(state_reg.word[8]);
	assign reloadState = mcuri_pkg::mcuri_reload_s'(state_reg.word[9]);

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstnSync);

	a_pin_holds_core: assert property (pinSync |=> coreHold)
		else $error("core left reset while pin high");
	a_cpu_init: assert property ($past(coreHold) |->
		cpuState.programCounter == 14'h0000
		&& cpuState.branchStatusFlag
		&& cpuState.stackPointer == 10'h3FF)
		else $error("cpu state not initialised");
	a_intr_clear: assert property ($past(coreHold) |->
		!intrState.globalInterruptEnable
		&& intrState.interruptRequestFlag == 6'h00)
		else $error("interrupt enable or request not cleared");
	a_mask_set: assert property (
		coreHold && $past(coreHold) |-> &intrState.interruptMaskBit)
		else $error("interrupt mask not set");
	a_port_high: assert property (
		$past(holdReq) |-> &portData.portOutputData)
		else $error("port data not all ones");
	a_dir_clear: assert property (
		$past(coreHold) |-> portDir == mcuri_pkg::mcuri_pdir_s'(0))
		else $error("port direction not cleared");
	a_pcfg_clear: assert property ($past(coreHold) |->
		portCfg.portConfigA == 2'h0 && !portCfg.portConfigB
		&& portCfg.portConfigC[3:1] == 3'h0)
		else $error("port config not cleared");
	a_edge_clear: assert property (
		$past(coreHold) |-> portCfg.edgeSelectSecond == 2'h0)
		else $error("edge select not cleared");
	a_timer_clear: assert property ($past(coreHold) |->
		countState == mcuri_pkg::mcuri_count_s'(0)
		&& prescState == mcuri_pkg::mcuri_presc_s'(0)
		&& reloadState.timerCReloadLow == 4'h0
		&& reloadState.timerDReloadLow == 4'h0
		&& timerCfg.timerAConfig == 3'h0)
		else $error("timer state not cleared");
	a_serial_clear: assert property ($past(coreHold) |->
		serCmp.serialConfigA == 4'h0 && !serCmp.serialConfigB[0])
		else $error("serial config not cleared");
	a_cmp_clear: assert property (
		$past(coreHold) |-> serCmp.comparatorEnableReg == 4'h0)
		else $error("comparator enable not cleared");
	a_flags_clear: assert property ($past(coreHold) |->
		!serCmp.watchdogActiveFlag && !serCmp.captureStatusFlag
		&& !serCmp.captureErrorFlag)
		else $error("bit register flags not cleared");
	a_misc_clear: assert property (
		$past(coreHold) |-> timerCfg.miscConfig == 2'h0)
		else $error("misc config not cleared");
	a_fetch_release: assert property ($rose(fetchEnable) |->
		$past(inStart) && $past(tick) && !$past(holdReq))
		else $error("fetch began without a clean release");
	a_ack_one: assert property (wbAck |=> !wbAck)
		else $error("ack held longer than one cycle");

	c_pin_reset: cover property (pinSync ##1 coreHold ##[1:40] fetchEnable);
	c_soft_reset: cover property ($rose(state_reg.softReset));
	c_hold_met: cover property (coreHold && holdMet);
	c_word_write: cover property (busReq && wbWe && wordHit);

endmodule // mcuri_reset_initializer

/* File: verif/mcuri_supervisor_model.sv */
// Board-level supervisor model driving the active-high reset pin
`timescale 1ns/100ps

module mcuri_supervisor_model #(
	parameter int MIN_HOLD = 4,
	parameter int SETTLE   = 120
) (
	// Clock
	input  wire logic        clk,
	// Hold request from the bench
	input  wire logic        go,
	input  wire logic [15:0] len,
	// Reset pin, active high
	output logic             resetPin
);
	// ----------------------------------------------------------------------
	// Pin sequencing
	// ----------------------------------------------------------------------
	int cnt = SETTLE;

	// Pin starts high for the whole oscillator settle time
	initial resetPin = 1'b1;

	always @(posedge clk) begin
		if (go) begin
			// Never shorter than two instruction cycles
			cnt      <= (len < MIN_HOLD) ? MIN_HOLD : int'(len);
			resetPin <= 1'b1;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else begin
			cnt      <= 0;
			resetPin <= 1'b0;
		end
	end
endmodule // mcuri_supervisor_model

/* File: verif/mcuri_reset_initializer_test.sv */
// Self-checking bench of the reset initializer
`timescale 1ns/100ps
`include "mcuri_consts.svh"
`define CHK(what, expv, gotv) begin \
	nTests++; \
	if ((gotv) !== (expv)) begin \
		failures++; \
		$display("CHECK FAILED %s exp %h got %h", what, expv, gotv); \
	end \
end

module mcuri_reset_initializer_test;
	localparam int DIV  = 2;
	localparam int MINH = 2 * DIV;
	localparam logic [31:0] INITV [10] = '{`MCURI_INIT_CPU, `MCURI_INIT_INTR,
		`MCURI_INIT_PDATA, 0, 0, 0, 0, 0, 0, 0};
	localparam logic [31:0] FORCEV [10] = '{`MCURI_FORCE_CPU,
		`MCURI_FORCE_INTR, `MCURI_FORCE_PDATA, `MCURI_FORCE_PDIR,
		`MCURI_FORCE_PCFG, `MCURI_FORCE_TCFG, `MCURI_FORCE_SERCMP,
		`MCURI_FORCE_PRESC, `MCURI_FORCE_COUNT, `MCURI_FORCE_RELOAD};
	localparam logic [31:0] WMASK [10] = '{`MCURI_FORCE_CPU,
		`MCURI_FORCE_INTR, `MCURI_FORCE_PDATA, `MCURI_FORCE_PDIR,
		`MCURI_MASK_PCFG, `MCURI_FORCE_TCFG, `MCURI_MASK_SERCMP,
		`MCURI_FORCE_PRESC, `MCURI_FORCE_COUNT, `MCURI_MASK_RELOAD};

	logic                     clk = 1'b0;
	logic                     rstn, resetPin, go;
	logic [15:0]              len;
	logic                     wbCyc, wbStb, wbWe, wbAck;
	logic [7:0]               wbAdr;
	logic [3:0]               wbSel;
	logic [31:0]              wbDatI, wbDatO;
	logic                     coreHold, fetchEnable, instrTick;
	mcuri_pkg::mcuri_cpu_s    cpuState;
	mcuri_pkg::mcuri_intr_s   intrState;
	mcuri_pkg::mcuri_pdata_s  portData;
	mcuri_pkg::mcuri_pdir_s   portDir;
	mcuri_pkg::mcuri_pcfg_s   portCfg;
	mcuri_pkg::mcuri_tcfg_s   timerCfg;
	mcuri_pkg::mcuri_sercmp_s serCmp;
	mcuri_pkg::mcuri_presc_s  prescState;
	mcuri_pkg::mcuri_count_s  countState;
	mcuri_pkg::mcuri_reload_s reloadState;
	logic [31:0]              outWord [10];
	logic [31:0]              expW [10] = '{default: 0};
	logic [31:0]              rd, wd;
	int                       failures = 0;
	int                       nTests = 0;
	int                       r, i;

	always #5 clk = ~clk;

	assign outWord = '{cpuState, intrState, portData, portDir, portCfg,
		timerCfg, serCmp, prescState, countState, reloadState};

	mcuri_reset_initializer #(.INSTR_DIV(DIV)) u_mcuri_reset_initializer (
		.clk(clk), .rstn(rstn), .resetPin(resetPin), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
		.wbDatI(wbDatI), .wbAck(wbAck), .wbDatO(wbDatO),
		.coreHold(coreHold), .fetchEnable(fetchEnable),
		.instrTick(instrTick), .cpuState(cpuState), .intrState(intrState),
		.portData(portData), .portDir(portDir), .portCfg(portCfg),
		.timerCfg(timerCfg), .serCmp(serCmp), .prescState(prescState),
		.countState(countState), .reloadState(reloadState));

	mcuri_supervisor_model #(.MIN_HOLD(MINH)) u_mcuri_supervisor_model (
		.clk(clk), .go(go), .len(len), .resetPin(resetPin));

	// ----------------------------------------------------------------------
	// Expectations, bus cycles and waits
	// ----------------------------------------------------------------------
	function automatic logic [31:0] afterReset(input int k);
		return (expW[k] & ~FORCEV[k]) | INITV[k];
	endfunction

	task close_out;
		if (failures == 0 && nTests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Entered just after a rising edge; returns just after one
	task automatic busCycle(input logic we, input logic [7:0] adr,
			input logic [31:0] dat, output logic [31:0] rdat);
		int k;
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= adr;
		wbSel  <= 4'hF;
		wbDatI <= dat;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (wbAck === 1'b1)
				break;
		end
		rdat = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk);
		if (k == 20) begin
			failures++;
			close_out;
		end
	endtask

	task automatic waitHold(input logic want, input int lim);
		int k;
		for (k = 0; k < lim; k++) begin
			@(posedge clk);
			if (coreHold === want)
				break;
		end
		if (k == lim) begin
			failures++;
			close_out;
		end
	endtask

	task automatic checkAll;
		logic [31:0] v;
		for (int k = 0; k < 10; k++) begin
			busCycle(1'b0, 8'(8 + 4 * k), 32'h0000_0000, v);
			`CHK("word", afterReset(k), v)
			`CHK("port", afterReset(k), outWord[k])
		end
	endtask

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		rstn = 1'b0; go = 1'b0; len = 16'h0000;
		wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0;
		wbAdr = 8'h00; wbSel = 4'h0; wbDatI = 32'h0000_0000;
		void'($urandom(32'hfeb9d837));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("hold", 1'b1, coreHold)
		`CHK("fetch", 1'b0, fetchEnable)
		checkAll;
		busCycle(1'b0, `MCURI_OFS_STATUS, 32'h0000_0000, rd);
		`CHK("status", 4'b1101, rd[3:0])
		waitHold(1'b0, 200);
		`CHK("fetch", 1'b1, fetchEnable)
		for (r = 0; r < 4; r++) begin
			for (i = 0; i < 10; i++) begin
				wd = $urandom;
				expW[i] = wd & WMASK[i];
				busCycle(1'b1, 8'(8 + 4 * i), wd, rd);
				busCycle(1'b0, 8'(8 + 4 * i), 32'h0000_0000, rd);
				`CHK("readback", expW[i], rd)
			end
			// First round uses the shortest legal pulse
			len <= (r == 0) ? 16'(MINH) : 16'(30 + $urandom_range(9, 0));
			go  <= 1'b1;
			@(posedge clk);
			go  <= 1'b0;
			waitHold(1'b1, 8);
			if (r > 0) begin
				i = $urandom_range(9, 0);
				busCycle(1'b1, 8'(8 + 4 * i), 32'hFFFF_FFFF, rd);
				expW[i] = WMASK[i];
				`CHK("held", 1'b1, coreHold)
			end
			waitHold(1'b0, 200);
			`CHK("fetch", 1'b1, fetchEnable)
			checkAll;
		end
		busCycle(1'b1, 8'h30, $urandom, rd);
		busCycle(1'b0, 8'h30, 32'h0000_0000, rd);
		`CHK("unmapped", 32'h0000_0000, rd)
		busCycle(1'b1, `MCURI_OFS_STATUS, 32'hFFFF_FFFF, rd);
		busCycle(1'b0, `MCURI_OFS_STATUS, 32'h0000_0000, rd);
		`CHK("status", 3'b010, rd[2:0])
		busCycle(1'b1, `MCURI_OFS_CTRL, 32'h0000_0001, rd);
		waitHold(1'b1, 8);
		checkAll;
		busCycle(1'b1, `MCURI_OFS_CTRL, 32'h0000_0000, rd);
		waitHold(1'b0, 200);
		`CHK("fetch", 1'b1, fetchEnable)
		close_out;
	end
endmodule // mcuri_reset_initializer_test
